// ---- adcso_top.sv ----
// Sequencer, serial shifter and result FIFO of the converter output logic.
`timescale 1ns/1ps

module adcso_fifo #(
	parameter int W = 24,
	parameter int D = 16
) (
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_reg, rd_reg;
	logic [AW:0]   count_reg, count_next;
	logic          ready_reg;
	logic          push, pop;

	assign push      = in_valid & ready_reg;
	assign pop       = out_ready & out_valid;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_reg];
	assign in_ready  = ready_reg;

	always_comb begin
		count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			count_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			if (push) begin
				mem[wr_reg] <= in_data;
				wr_reg      <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
			end
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(D));
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module adcso_top
	import adcso_pkg::*;
#(
	parameter int ISCK_HALF_CYCLES   = ISCK_HALF,
	parameter int EXT_TIMEOUT_CYCLES = EXT_TIMEOUT
) (
	input  wire logic              CLOCK,
	input  wire logic              RESET,
	input  wire logic              CS_N,
	input  wire logic              SCK_IN,
	output logic                   SCK_OUT,
	output logic                   SCK_OE,
	output logic                   SCK_PULLUP_EN,
	output logic                   SDO_OUT,
	output logic                   SDO_OE,
	input  wire logic              FREQUENCY_SELECT_PIN,
	output logic                   EXT_SYS_CLOCK,
	output logic                   NOTCH_50HZ,
	output logic                   FILTER_TICK,
	output logic                   CONV_START,
	output logic                   SLEEP,
	input  wire logic              RESULT_VALID,
	input  wire logic [DATA_W-1:0] RESULT_DATA,
	output logic                   RESULT_READY
);
	logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3, f_s1, f_s2, f_s3;
	logic cs_fall, ext_rise, ext_fall, f_rise, f_edge;
	logic fifo_valid, fifo_pop, fifo_ready;
	logic [DATA_W-1:0] fifo_data;

	adcso_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
		.clock     (CLOCK),
		.reset     (RESET),
		.in_valid  (RESULT_VALID),
		.in_data   (RESULT_DATA),
		.in_ready  (fifo_ready),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers; only the second and third stages are looked at.
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			{cs_s1, cs_s2, cs_s3}    <= 3'h7;
			{sck_s1, sck_s2, sck_s3} <= 3'h7;
			{f_s1, f_s2, f_s3}       <= 3'h0;
		end else begin
			{cs_s1, cs_s2, cs_s3}    <= {CS_N, cs_s1, cs_s2};
			{sck_s1, sck_s2, sck_s3} <= {SCK_IN, sck_s1, sck_s2};
			{f_s1, f_s2, f_s3}       <= {FREQUENCY_SELECT_PIN, f_s1, f_s2};
		end
	end
	assign cs_fall  = cs_s3 & ~cs_s2;
	assign ext_rise = ~sck_s3 & sck_s2;
	assign ext_fall = sck_s3 & ~sck_s2;
	assign f_rise   = ~f_s3 & f_s2;
	assign f_edge   = f_s3 ^ f_s2;

	////////////////////////////////////////////////////////////////////////////
	// Frequency pin: steady level picks the notch, toggling is a system clock.
	logic [15:0] idle_reg, idle_next;
	logic [11:0] null_reg, null_next;
	logic        ext_reg, ext_next, n50_reg, n50_next, tick_reg, tick_next;

	always_comb begin
		idle_next = f_edge ? '0 : ((idle_reg == 16'(EXT_TIMEOUT_CYCLES)) ? idle_reg
		                           : idle_reg + 16'h0001);
		ext_next  = f_edge | (ext_reg & (idle_reg != 16'(EXT_TIMEOUT_CYCLES)));
		n50_next  = ~ext_next & f_s2;
		null_next = null_reg;
		tick_next = 1'b0;
		if (!ext_next) begin
			null_next = '0;
		end else if (f_rise) begin
			tick_next = (null_reg == NULL_LAST);
			null_next = tick_next ? '0 : null_reg + 12'h001;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			idle_reg <= '0;
			null_reg <= '0;
			ext_reg  <= 1'b0;
			n50_reg  <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			idle_reg <= idle_next;
			null_reg <= null_next;
			ext_reg  <= ext_next;
			n50_reg  <= n50_next;
			tick_reg <= tick_next;
		end
	end
	assign EXT_SYS_CLOCK = ext_reg;
	assign NOTCH_50HZ    = n50_reg;
	assign FILTER_TICK   = tick_reg;

	////////////////////////////////////////////////////////////////////////////
	// Conversion, sleep and data output sequencer with the result shifter.
	adcso_state_e      state_reg, state_next;
	logic [DATA_W-1:0] shift_reg, shift_next;
	logic [4:0]        bit_reg, bit_next;
	logic [15:0]       div_reg, div_next;
	logic mode_ext_reg, mode_ext_next, init_reg, init_next, sck_reg, sck_next;
	logic sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next, sck_oe_reg, sck_oe_next;
	logic pull_reg, pull_next, sleep_reg, sleep_next, start_reg, start_next;
	logic active, toggle, rise, fall;

	assign active   = (state_reg == ST_ARMED) | (state_reg == ST_SHIFT);
	assign toggle   = ~mode_ext_reg & active & (div_reg == 16'(ISCK_HALF_CYCLES - 1));
	assign rise     = mode_ext_reg ? ext_rise : (toggle & ~sck_reg);
	assign fall     = mode_ext_reg ? ext_fall : (toggle & sck_reg);
	assign fifo_pop = (state_reg == ST_CONVERT) & fifo_valid;

	always_comb begin
		state_next    = state_reg;
		shift_next    = shift_reg;
		bit_next      = bit_reg;
		mode_ext_next = mode_ext_reg;
		init_next     = 1'b1;
		start_next    = ~init_reg;
		div_next      = toggle ? '0 : div_reg + 16'h0001;
		sck_next      = toggle ? ~sck_reg : sck_reg;
		if (!init_reg || cs_fall) begin
			mode_ext_next = ~sck_s2;
		end
		case (state_reg)
			ST_CONVERT: begin
				if (fifo_valid) begin
					shift_next = fifo_data;
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!cs_s2) begin
					state_next = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (cs_s2) begin
					state_next = ST_SLEEP;
				end else if (rise) begin
					bit_next   = BIT_FIRST;
					state_next = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (cs_s2) begin
					state_next = ST_CONVERT;
					start_next = 1'b1;
				end else if (fall) begin
					shift_next = {shift_reg[DATA_W-2:0], 1'b0};
				end else if (rise) begin
					if (bit_reg == BIT_LAST) begin
						state_next = ST_CONVERT;
						start_next = 1'b1;
					end else begin
						bit_next = bit_reg + 5'h01;
					end
				end
			end
			default: begin
				state_next = ST_CONVERT;
			end
		endcase
		if ((state_next != ST_ARMED) && (state_next != ST_SHIFT)) begin
			div_next = '0;
			sck_next = 1'b0;
		end
		sdo_oe_next = ~cs_s2;
		case (state_next)
			ST_CONVERT: sdo_next = STATUS_BUSY;
			ST_SLEEP:   sdo_next = STATUS_READY;
			default:    sdo_next = shift_next[DATA_W-1];
		endcase
		sck_oe_next = ~mode_ext_next & ((state_next == ST_ARMED) | (state_next == ST_SHIFT));
		pull_next   = ~mode_ext_next;
		sleep_next  = (state_next == ST_SLEEP) & cs_s2;
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			state_reg    <= ST_CONVERT;
			shift_reg    <= '0;
			bit_reg      <= '0;
			div_reg      <= '0;
			mode_ext_reg <= 1'b0;
			init_reg     <= 1'b0;
			sck_reg      <= 1'b0;
			sdo_reg      <= STATUS_BUSY;
			sdo_oe_reg   <= 1'b0;
			sck_oe_reg   <= 1'b0;
			pull_reg     <= 1'b1;
			sleep_reg    <= 1'b0;
			start_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			shift_reg    <= shift_next;
			bit_reg      <= bit_next;
			div_reg      <= div_next;
			mode_ext_reg <= mode_ext_next;
			init_reg     <= init_next;
			sck_reg      <= sck_next;
			sdo_reg      <= sdo_next;
			sdo_oe_reg   <= sdo_oe_next;
			sck_oe_reg   <= sck_oe_next;
			pull_reg     <= pull_next;
			sleep_reg    <= sleep_next;
			start_reg    <= start_next;
		end
	end
	assign SCK_OUT       = sck_reg;
	assign SCK_OE        = sck_oe_reg;
	assign SCK_PULLUP_EN = pull_reg;
	assign SDO_OUT       = sdo_reg;
	assign SDO_OE        = sdo_oe_reg;
	assign SLEEP         = sleep_reg;
	assign CONV_START    = start_reg;
	assign RESULT_READY  = fifo_ready;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	property p_oe_on;    !cs_s2 |=> SDO_OE; endproperty
	a_oe_on:    assert property (p_oe_on) else $error("output not enabled");
	property p_oe_off;   cs_s2 |=> !SDO_OE; endproperty
	a_oe_off:   assert property (p_oe_off) else $error("output not released");
	property p_sleep;    state_reg == ST_SLEEP && cs_s2 |=> state_reg == ST_SLEEP && SLEEP; endproperty
	a_sleep:    assert property (p_sleep) else $error("left sleep");
	property p_abort;    state_reg == ST_SHIFT && cs_s2 |=> state_reg == ST_CONVERT && CONV_START;
	endproperty
	a_abort:    assert property (p_abort) else $error("abort failed");
	property p_status;   state_reg == ST_CONVERT |-> SDO_OUT == STATUS_BUSY; endproperty
	a_status:   assert property (p_status) else $error("bad status");
	property p_drive;    SCK_OE |-> active && !mode_ext_reg; endproperty
	a_drive:    assert property (p_drive) else $error("clock driven wrongly");
	property p_pull;     SCK_PULLUP_EN == !mode_ext_reg; endproperty
	a_pull:     assert property (p_pull) else $error("pull-up mismatch");
	property p_mode;     cs_fall |=> mode_ext_reg == !$past(sck_s2); endproperty
	a_mode:     assert property (p_mode) else $error("mode not captured");
	property p_n50;      f_s2 && f_s3 && !EXT_SYS_CLOCK |=> NOTCH_50HZ; endproperty
	a_n50:      assert property (p_n50) else $error("notch not 50");
	property p_n60;      !f_s2 |=> !NOTCH_50HZ; endproperty
	a_n60:      assert property (p_n60) else $error("notch not 60");
	property p_keep;     state_reg == ST_ARMED && cs_s2 |=>
	                     state_reg == ST_SLEEP && shift_reg == $past(shift_reg); endproperty
	a_keep:     assert property (p_keep) else $error("result lost");
	property p_shift;    state_reg == ST_SHIFT && !cs_s2 && fall |=>
	                     shift_reg == {$past(shift_reg[DATA_W-2:0]), 1'b0}; endproperty
	a_shift:    assert property (p_shift) else $error("bad shift");
	property p_end;      state_reg == ST_SHIFT && !cs_s2 && rise && bit_reg == BIT_LAST |=>
	                     state_reg == ST_CONVERT && CONV_START && SDO_OUT == STATUS_BUSY;
	endproperty
	a_end:      assert property (p_end) else $error("no end after last bit");
	property p_wake;     state_reg == ST_SLEEP && !cs_s2 |=> state_reg == ST_ARMED; endproperty
	a_wake:     assert property (p_wake) else $error("no wake");
	property p_sync;     cs_s2 == $past(CS_N, 2) && sck_s2 == $past(SCK_IN, 2); endproperty
	a_sync:     assert property (p_sync) else $error("pin not synchronised");

	c_full:  cover property (state_reg == ST_SHIFT && rise && bit_reg == BIT_LAST && !cs_s2);
	c_abort: cover property (state_reg == ST_SHIFT && cs_s2);
	c_early: cover property (state_reg == ST_ARMED && cs_s2);
	c_ext:   cover property (state_reg == ST_SHIFT && mode_ext_reg && ext_rise);
endmodule

// ---- adcso_pkg.sv ----
// Shared constants and state type for the converter serial output control block.
package adcso_pkg;
	localparam int          CLK_HZ          = 200000000;
	localparam int          ISCK_HZ         = 19200;
	localparam int          ISCK_HALF       = CLK_HZ / (2 * ISCK_HZ);
	localparam int          EXT_HIGH_MAX_US = 200;
	localparam int          EXT_TIMEOUT     = EXT_HIGH_MAX_US * (CLK_HZ / 1000000);
	localparam int          NULL_DIV        = 2560;
	localparam int          DATA_W          = 24;
	localparam int          BIT_COUNT       = 24;
	localparam int          FIFO_DEPTH      = 16;
	localparam logic [4:0]  BIT_FIRST       = 5'h01;
	localparam logic [4:0]  BIT_LAST        = 5'(BIT_COUNT - 1);
	localparam logic [11:0] NULL_LAST       = 12'(NULL_DIV - 1);
	localparam logic        STATUS_BUSY     = 1'b1;
	localparam logic        STATUS_READY    = 1'b0;
	typedef enum logic [3:0] {
		ST_CONVERT = 4'h1,
		ST_SLEEP   = 4'h2,
		ST_ARMED   = 4'h4,
		ST_SHIFT   = 4'h8
	} adcso_state_e;
endpackage

// ---- adcso_host.sv ----
// Host serial master model that picks the clock mode and reads result words.
`timescale 1ns/1ps

module adcso_host (
	input  wire logic clock,
	input  wire logic sck_out,
	input  wire logic sck_oe,
	input  wire logic sck_pullup_en,
	input  wire logic sdo_out,
	input  wire logic sdo_oe,
	output logic      cs_n,
	output logic      sck_pin,
	output logic      sdo_pin
);
	logic host_en = 1'b1;
	logic host_sck = 1'b1;
	logic flip = 1'b0;
	initial cs_n = 1'b1;
	always @(posedge clock) flip <= ~flip;
	// Undriven lines show a changing pattern unless the pull-up holds the clock line high.
	assign sck_pin = sck_oe ? sck_out : host_en ? host_sck : (sck_pullup_en | flip);
	assign sdo_pin = sdo_oe ? sdo_out : flip;
	// The clock level held across the chip-select fall picks the mode.
	task automatic select(input logic ext);
		@(posedge clock);
		host_en <= 1'b1;
		host_sck <= !ext;
		repeat (4) @(posedge clock);
		cs_n <= 1'b0;
		repeat (5) @(posedge clock);
		host_en <= ext;
	endtask
	// With the internal clock the data pin may change on the very edge that raises the clock.
	// The bit taken is therefore the one that stood just before that edge.
	task automatic shift(input logic ext, input int n, output logic [23:0] w);
		logic s_prev;
		logic d_prev;
		w = '0;
		for (int i = 0; i < n; i++) begin
			if (ext) begin
				repeat (6) @(posedge clock);
				host_sck <= 1'b1;
				d_prev = sdo_pin;
			end else begin
				s_prev = sck_pin;
				d_prev = sdo_pin;
				@(posedge clock);
				while (!(s_prev === 1'b0 && sck_pin === 1'b1)) begin
					s_prev = sck_pin;
					d_prev = sdo_pin;
					@(posedge clock);
				end
			end
			w = {w[22:0], d_prev};
			if (ext) begin
				repeat (6) @(posedge clock);
				host_sck <= 1'b0;
			end
		end
	endtask
	task automatic deselect();
		@(posedge clock);
		cs_n <= 1'b1;
	endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the converter serial output control block.
`timescale 1ns/1ps

module tb_top import adcso_pkg::*;;
	logic              CLOCK, RESET, CS_N, SCK_PIN, SDO_PIN, FREQUENCY_SELECT_PIN;
	logic              SCK_OUT, SCK_OE, SCK_PULLUP_EN, SDO_OUT, SDO_OE, EXT_SYS_CLOCK;
	logic              NOTCH_50HZ, FILTER_TICK, CONV_START, SLEEP, RESULT_VALID, RESULT_READY;
	logic [DATA_W-1:0] RESULT_DATA;
	int                err_count = 0;
	int                compares = 0;
	int                cycles = 0;
	int                conv_cnt = 0;

	adcso_top #(.ISCK_HALF_CYCLES(8), .EXT_TIMEOUT_CYCLES(64)) uut (
		.CLOCK(CLOCK), .RESET(RESET), .CS_N(CS_N), .SCK_IN(SCK_PIN), .SCK_OUT(SCK_OUT),
		.SCK_OE(SCK_OE), .SCK_PULLUP_EN(SCK_PULLUP_EN), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE),
		.FREQUENCY_SELECT_PIN(FREQUENCY_SELECT_PIN), .EXT_SYS_CLOCK(EXT_SYS_CLOCK),
		.NOTCH_50HZ(NOTCH_50HZ), .FILTER_TICK(FILTER_TICK), .CONV_START(CONV_START),
		.SLEEP(SLEEP), .RESULT_VALID(RESULT_VALID), .RESULT_DATA(RESULT_DATA),
		.RESULT_READY(RESULT_READY));
	adcso_host host (.clock(CLOCK), .sck_out(SCK_OUT), .sck_oe(SCK_OE),
		.sck_pullup_en(SCK_PULLUP_EN), .sdo_out(SDO_OUT), .sdo_oe(SDO_OE), .cs_n(CS_N),
		.sck_pin(SCK_PIN), .sdo_pin(SDO_PIN));

	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cycles <= cycles + 1;
		if (CONV_START === 1'b1) conv_cnt <= conv_cnt + 1;
		if (cycles == 70000) begin
			err_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [23:0] wd(input int i);
		return 24'h5A3C96 ^ 24'(i * 24'h0B1D07);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_status();
		host.select(1'b1);
		check(SDO_OE, 1'b1);
		check(SDO_OUT, STATUS_BUSY);
		check(SLEEP, 1'b0);
		host.deselect();
		repeat (6) @(posedge CLOCK);
		check(SDO_OE, 1'b0);
		$display("status test done");
	endtask
	task automatic t_fill();
		int n;
		RESULT_VALID <= 1'b1;
		RESULT_DATA <= wd(0);
		do @(posedge CLOCK); while (RESULT_READY !== 1'b1);
		RESULT_VALID <= 1'b0;
		repeat (6) @(posedge CLOCK);
		check(SLEEP, 1'b1);
		n = 0;
		RESULT_VALID <= 1'b1;
		for (int k = 0; k < 20; k++) begin
			RESULT_DATA <= wd(n + 1);
			@(posedge CLOCK);
			if (RESULT_READY === 1'b1) n++;
		end
		RESULT_VALID <= 1'b0;
		check(n, FIFO_DEPTH);
		check(RESULT_READY, 1'b0);
		$display("fill test done");
	endtask
	task automatic t_read(input logic ext, input int i);
		logic [23:0] w;
		int c;
		host.select(ext);
		check(SCK_OE, !ext);
		check(SCK_PULLUP_EN, !ext);
		c = conv_cnt;
		host.shift(ext, 24, w);
		host.deselect();
		check(w, wd(i));
		repeat (8) @(posedge CLOCK);
		check(conv_cnt, c + 1);
		check(SDO_OE, 1'b0);
		check(SLEEP, 32'(i < 16));
		$display("read %0d done", i);
	endtask
	task automatic t_early(input int i);
		int c;
		c = conv_cnt;
		host.select(1'b1);
		host.deselect();
		repeat (6) @(posedge CLOCK);
		check(SLEEP, 1'b1);
		check(conv_cnt, c);
		t_read(1'b1, i);
	endtask
	task automatic t_abort(input int i);
		logic [23:0] w;
		int c;
		host.select(1'b1);
		c = conv_cnt;
		host.shift(1'b1, 5, w);
		host.deselect();
		repeat (8) @(posedge CLOCK);
		check(w[4:0], wd(i) >> 19);
		check(conv_cnt, c + 1);
		$display("abort test done");
	endtask
	task automatic t_freq();
		int t0;
		int n;
		check(NOTCH_50HZ, 1'b1);
		FREQUENCY_SELECT_PIN <= 1'b0;
		repeat (100) @(posedge CLOCK);
		check(NOTCH_50HZ, 1'b0);
		check(EXT_SYS_CLOCK, 1'b0);
		t0 = 0;
		n = 0;
		for (int k = 0; k < 8 * NULL_DIV * 3 && n < 2; k++) begin
			@(posedge CLOCK);
			FREQUENCY_SELECT_PIN <= k[2];
			if (FILTER_TICK === 1'b1) begin
				if (n == 1) check(k - t0, NULL_DIV * 8);
				t0 = k;
				n++;
			end
		end
		check(EXT_SYS_CLOCK, 1'b1);
		FREQUENCY_SELECT_PIN <= 1'b1;
		repeat (100) @(posedge CLOCK);
		check(EXT_SYS_CLOCK, 1'b0);
		check(NOTCH_50HZ, 1'b1);
		$display("frequency test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		RESET = 1'b1;
		RESULT_VALID = 1'b0;
		RESULT_DATA = '0;
		FREQUENCY_SELECT_PIN = 1'b1;
		repeat (2) @(posedge CLOCK);
		RESET <= 1'b0;
		repeat (4) @(posedge CLOCK);
		t_status();
		t_fill();
		t_read(1'b1, 0);
		t_read(1'b0, 1);
		t_early(2);
		t_abort(3);
		for (int i = 4; i <= 16; i++) t_read(i[0], i);
		check(RESULT_READY, 1'b1);
		t_freq();
		conclude();
	end
endmodule
